// File: emi_pkg.sv
// Shared constants, types and register map of the wide memory interface control block
package emi_pkg;

   // Register port geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CFG  = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;

   // Control register fields
   localparam int unsigned CTRL_DIV_LSB = 0;   // 2 bits: output clock 2 divide select
   localparam int unsigned CTRL_SR_BIT  = 2;   // SDRAM self-refresh request
   localparam int unsigned CTRL_GP_BIT  = 3;   // Clock-enable pin value when no SDRAM

   // Space configuration fields
   localparam int unsigned CFG_TYPE_LSB = 0;   // 2 bits per space, spaces 0..3
   localparam int unsigned CFG_ROLE_LSB = 8;   // 1 bit per space: strobe_role_select

   // Status register fields
   localparam int unsigned STAT_SRC_LSB   = 0; // 2 bits: selected clock source
   localparam int unsigned STAT_GRANT_BIT = 2;
   localparam int unsigned STAT_BUSY_BIT  = 3;
   localparam int unsigned STAT_PEND_BIT  = 4;
   localparam int unsigned STAT_CKE_BIT   = 5;

   // Reset values
   localparam logic [3:0]  CTRL_RST = 4'h0;
   localparam logic [11:0] CFG_RST  = 12'h000;

   // Timing counts, in interface clock ticks
   localparam logic [1:0] SETUP_TICKS  = 2'h1;
   localparam logic [1:0] STROBE_TICKS = 2'h2;

   // Core clock half periods for the divided sources
   localparam logic [1:0] HALF_DIV4 = 2'h2;
   localparam logic [1:0] HALF_DIV6 = 2'h3;

   // Interface clock source
   typedef enum logic [1:0] {
      EMI_SRC_EXT,
      EMI_SRC_DIV4,
      EMI_SRC_DIV6
   } emi_src_t;

   // Output clock 2 divide factor
   typedef enum logic [1:0] {
      EMI_DIV1,
      EMI_DIV2,
      EMI_DIV4
   } emi_div_t;

   // Memory type of a chip-enable space
   typedef enum logic [1:0] {
      EMI_MEM_ASYNC,
      EMI_MEM_SDRAM,
      EMI_MEM_SYNC,
      EMI_MEM_NONE
   } emi_mem_t;

   // External control pins, all strobes active low
   typedef struct packed {
      logic [3:0] ce_n;        // Chip enables, space 3 down to 0
      logic       rd_n;        // Read / column strobe / address strobe pin
      logic       oe_n;        // shared_output_enable / row strobe pin
      logic       we_n;        // Write strobe pin, all memory types
      logic       fifo_oe_n;   // fifo_space_output_enable
      logic       drive;       // Output enable of all pins above
   } emi_pins_t;

   // Core-side access request
   typedef struct packed {
      logic       valid;       // Held until done
      logic       wr;
      logic [3:0] addr_hi;     // Word-address bits 31..28
   } emi_req_t;

endpackage

// File: emi_clkgen.sv
// Interface clock selection and generation of the two memory output clocks
`timescale 1ns/1ps
module emi_clkgen
   import emi_pkg::*;
(
   input  wire logic     core_clk,
   input  wire logic     reset_n,
   input  wire logic     run,
   input  emi_src_t      src,
   input  emi_div_t      div,
   input  wire logic     iface_clock_in,
   output logic          tick,
   output logic          clk1,
   output logic          clk2
);

   typedef struct packed {
      logic [1:0] cnt;
      logic [1:0] dcnt;
      logic       clk1;
      logic       clk2;
      logic       tick;
   } emi_cg_t;

   emi_cg_t s_q;
   emi_cg_t s_d;
   logic    half;
   logic    rise;

   // Half-period enable from the chosen source
   always_comb begin
      s_d  = s_q;
      half = 1'b0;
      if (run) begin
         if (src == EMI_SRC_EXT) begin
            half = (iface_clock_in != s_q.clk1);   // RL2
         end else begin
            half = (s_q.cnt == ((src == EMI_SRC_DIV4) ? HALF_DIV4 : HALF_DIV6) - 2'h1); // RL1
            s_d.cnt = half ? 2'h0 : s_q.cnt + 2'h1;
         end
      end
      rise = half && !s_q.clk1;
      // Output clock 1 follows the interface clock with no division
      if (half) begin
         s_d.clk1 = !s_q.clk1;   // RL4
      end
      if (rise) begin
         s_d.dcnt = s_q.dcnt + 2'h1;
      end
      // Output clock 2 at interface rate divided by 1, 2 or 4
      case (div)
         EMI_DIV2: s_d.clk2 = s_d.dcnt[0];   // RL3
         EMI_DIV4: s_d.clk2 = s_d.dcnt[1];   // RL3
         default:  s_d.clk2 = s_d.clk1;      // RL3
      endcase
      s_d.tick = rise;
   end

   // Single state register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
   assign clk1 = s_q.clk1;
   assign clk2 = s_q.clk2;

endmodule

// File: emi_ctrl.sv
// Control side of the wide memory interface: clocks, arbitration and shared strobes
//
// Operation
// RL1: The interface clock comes from the external pin, core/4 or core/6, chosen by straps at reset.
// RL2: Straps that select nothing else leave the external clock pin as the source.
// RL3: Output clock 2 runs at the interface clock divided by a programmed one, two or four.
// RL4: Output clock 1 runs at the interface clock rate with no division.
// RL5: On a synchronous space the read pin is an address strobe when role select is 0, else a read enable.
// RL6: The read pin serves as async read enable, SDRAM column strobe or synchronous strobe by space type.
// RL7: The output-enable pin serves as async output enable, SDRAM row strobe or synchronous output enable.
// RL8: The write pin is the write enable for async, SDRAM and synchronous spaces alike.
// RL9: An SDRAM clock-enable output exists and is dropped to put SDRAM into self-refresh.
// RL10: With no SDRAM configured the clock-enable pin is a software-driven general output.
// RL11: A separate synchronous output enable follows chip-enable space 3 for a glueless FIFO.
// RL12: An async access holds its strobe until the memory ready input is seen high.
// RL13: A host that wants the bus raises the hold request input.
// RL14: An accepted hold request is answered by raising the hold grant output.
// RL15: The bus request output shows that an external access is pending.
// RL16: At most one of four chip enables is active in an access, decoded from word-address bits 31..28.
// RL17: While the grant stands, the pins float and no new access starts until the request drops.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module emi_ctrl
   import emi_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic [1:0]        clock_source_straps,
   input  wire logic              iface_clock_in,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   input  emi_req_t               acc_req,
   output logic                   acc_done,
   input  wire logic              async_wait_ready_in,
   input  wire logic              host_bus_claim_in,
   output logic                   hold_grant_out,
   output logic                   pending_access_flag_out,
   output emi_pins_t              mem_pins,
   output logic                   sdram_clk_enable,
   output logic                   full_rate_mem_clock_out,
   output logic                   divided_mem_clock_out
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE
   } emi_st_t;

   typedef struct packed {
      emi_st_t          st;
      logic [1:0]       cnt;
      logic [1:0]       space;
      logic             wr;
      emi_mem_t         mtype;
      logic             role;
      logic             strap_ok;
      emi_src_t         src;
      logic [3:0]       ctrl;
      logic [11:0]      cfg;
      logic             grant;
      logic             pend;
      logic             done;
      logic             cke;
      emi_pins_t        pins;
      logic [DATA_W-1:0] rdata;
   } emi_state_t;

   emi_state_t s_q;
   emi_state_t s_d;
   logic       tick;
   logic       clk1;
   logic       clk2;

   // Strap decode; unused codes fall back to the external pin
   function automatic emi_src_t strap_src(input logic [1:0] st);
      case (st)
         2'h1:    strap_src = EMI_SRC_DIV4;   // RL1
         2'h2:    strap_src = EMI_SRC_DIV6;   // RL1
         default: strap_src = EMI_SRC_EXT;    // RL2
      endcase
   endfunction

   // Memory type of one space from the configuration word
   function automatic emi_mem_t space_type(input logic [11:0] cfg, input logic [1:0] sp);
      space_type = emi_mem_t'(cfg[CFG_TYPE_LSB + 2*sp +: 2]);
   endfunction

   // Any space configured as SDRAM
   function automatic logic sdram_present(input logic [11:0] cfg);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 4; i++) begin
         hit = hit | (space_type(cfg, 2'(i)) == EMI_MEM_SDRAM);
      end
      sdram_present = hit;
   endfunction

   emi_clkgen u_clkgen (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .run            (s_q.strap_ok),
      .src            (s_q.src),
      .div            (emi_div_t'(s_q.ctrl[CTRL_DIV_LSB +: 2])),
      .iface_clock_in (iface_clock_in),
      .tick           (tick),
      .clk1           (clk1),
      .clk2           (clk2)
   );

   // Next-state logic for the whole block
   always_comb begin
      logic first;
      logic rd_acc;
      first  = 1'b0;
      rd_acc = 1'b0;
      s_d       = s_q;
      s_d.done  = 1'b0;
      s_d.rdata = '0;

      // Straps are caught on the first edge after reset release
      if (!s_q.strap_ok) begin
         s_d.strap_ok = 1'b1;
         s_d.src      = strap_src(clock_source_straps);   // RL1
      end

      // Register writes; reads answer in the next cycle, unmapped as zero
      if (reg_wr && reg_addr == REG_CTRL) begin
         s_d.ctrl = reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == REG_CFG) begin
         s_d.cfg = reg_wdata[11:0];
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: s_d.rdata = {28'h0, s_q.ctrl};
            REG_CFG:  s_d.rdata = {20'h0, s_q.cfg};
            REG_STAT: begin
               s_d.rdata[STAT_SRC_LSB +: 2] = s_q.src;
               s_d.rdata[STAT_GRANT_BIT]    = s_q.grant;
               s_d.rdata[STAT_BUSY_BIT]     = (s_q.st != ST_IDLE);
               s_d.rdata[STAT_PEND_BIT]     = s_q.pend;
               s_d.rdata[STAT_CKE_BIT]      = s_q.cke;
            end
            default: s_d.rdata = '0;
         endcase
      end

      // Hold arbitration; a running access finishes before the grant
      if (s_q.grant) begin
         if (!host_bus_claim_in) begin
            s_d.grant = 1'b0;   // RL17
         end
      end else if (host_bus_claim_in && s_q.st == ST_IDLE) begin
         s_d.grant = 1'b1;      // RL14
      end

      // Access sequencer, advanced on interface clock rising ticks
      case (s_q.st)
         ST_IDLE: begin
            if (tick && acc_req.valid && !s_q.done && !s_q.grant && !host_bus_claim_in) begin // RL17
               s_d.wr    = acc_req.wr;
               s_d.space = acc_req.addr_hi[1:0];
               s_d.mtype = space_type(s_q.cfg, acc_req.addr_hi[1:0]);
               s_d.role  = s_q.cfg[CFG_ROLE_LSB + 32'(acc_req.addr_hi[1:0])];
               // Only 8..b of the top nibble map to a space
               if (acc_req.addr_hi[3:2] != 2'h2 || s_d.mtype == EMI_MEM_NONE) begin
                  s_d.done = 1'b1;
               end else begin
                  s_d.st  = ST_SETUP;
                  s_d.cnt = SETUP_TICKS - 2'h1;
               end
            end
         end
         ST_SETUP: begin
            if (tick) begin
               if (s_q.cnt == 2'h0) begin
                  s_d.st  = ST_STROBE;
                  s_d.cnt = STROBE_TICKS - 2'h1;
               end else begin
                  s_d.cnt = s_q.cnt - 2'h1;
               end
            end
         end
         ST_STROBE: begin
            if (tick) begin
               if (s_q.cnt != 2'h0) begin
                  s_d.cnt = s_q.cnt - 2'h1;
               end else if (s_q.mtype == EMI_MEM_ASYNC && !async_wait_ready_in) begin
                  s_d.st = ST_STROBE;   // RL12
               end else begin
                  s_d.st   = ST_IDLE;
                  s_d.done = 1'b1;
               end
            end
         end
         default: s_d.st = ST_IDLE;
      endcase

      // Pending access shown to outside arbitration
      s_d.pend = acc_req.valid && !s_d.done && !s_q.done;   // RL15

      // Clock enable: self-refresh with SDRAM, else a plain output
      if (sdram_present(s_d.cfg)) begin
         s_d.cke = !s_d.ctrl[CTRL_SR_BIT];   // RL9
      end else begin
         s_d.cke = s_d.ctrl[CTRL_GP_BIT];    // RL10
      end

      // Pin values registered from the next state so pins come from flops
      first  = (s_d.st == ST_STROBE) && (s_d.cnt == STROBE_TICKS - 2'h1);
      rd_acc = !s_d.wr;
      s_d.pins.drive     = !s_d.grant;   // RL17
      s_d.pins.ce_n      = 4'hf;
      s_d.pins.rd_n      = 1'b1;
      s_d.pins.oe_n      = 1'b1;
      s_d.pins.we_n      = 1'b1;
      s_d.pins.fifo_oe_n = 1'b1;
      if (s_d.st != ST_IDLE) begin
         s_d.pins.ce_n[s_d.space] = 1'b0;   // RL16
      end
      if (s_d.st == ST_STROBE) begin
         s_d.pins.we_n = !s_d.wr;           // RL8
      end
      case (s_d.mtype)
         EMI_MEM_ASYNC: begin
            s_d.pins.rd_n = !(rd_acc && s_d.st == ST_STROBE);   // RL6
            s_d.pins.oe_n = !(rd_acc && s_d.st != ST_IDLE);     // RL7
         end
         EMI_MEM_SDRAM: begin
            s_d.pins.oe_n = !(s_d.st == ST_SETUP);              // RL7
            s_d.pins.rd_n = !first;                             // RL6
         end
         EMI_MEM_SYNC: begin
            if (s_d.role) begin
               s_d.pins.rd_n = !(rd_acc && s_d.st == ST_STROBE);   // RL5
            end else begin
               s_d.pins.rd_n = !first;                             // RL5
            end
            s_d.pins.oe_n      = !(rd_acc && s_d.st == ST_STROBE); // RL7
            s_d.pins.fifo_oe_n = !(rd_acc && s_d.st == ST_STROBE
                                   && s_d.space == 2'h3);          // RL11
         end
         default: s_d.pins.rd_n = 1'b1;
      endcase
   end

   // Single state register; pins idle high and driven out of reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q       <= '0;
         s_q.ctrl  <= CTRL_RST;
         s_q.cfg   <= CFG_RST;
         s_q.pins  <= '{ce_n: 4'hf, rd_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        fifo_oe_n: 1'b1, drive: 1'b1};
         s_q.st    <= ST_IDLE;
         s_q.src   <= EMI_SRC_EXT;
         s_q.mtype <= EMI_MEM_ASYNC;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata               = s_q.rdata;
   assign acc_done                = s_q.done;
   assign hold_grant_out          = s_q.grant;
   assign pending_access_flag_out = s_q.pend;
   assign mem_pins                = s_q.pins;
   assign sdram_clk_enable        = s_q.cke;
   assign full_rate_mem_clock_out = clk1;
   assign divided_mem_clock_out   = clk2;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_ce_onehot: assert property ($onehot0(~mem_pins.ce_n))   // RL16
      else $error("more than one chip enable active");
   a_hold_float: assert property (hold_grant_out |-> !mem_pins.drive && mem_pins.ce_n == 4'hf) // RL17
      else $error("pins driven or access active during hold");
   a_grant_release: assert property (hold_grant_out && !host_bus_claim_in |=> !hold_grant_out) // RL17
      else $error("grant kept after request dropped");
   a_grant_answer: assert property (host_bus_claim_in && s_q.st == ST_IDLE |=> hold_grant_out) // RL14
      else $error("idle bus not granted to host");
   a_ready_wait: assert property (s_q.st == ST_STROBE && tick && s_q.cnt == 2'h0 // RL12
                                 && s_q.mtype == EMI_MEM_ASYNC && !async_wait_ready_in
                                 |=> s_q.st == ST_STROBE && !acc_done)
      else $error("async access ended without ready");
   // Clock enable is registered from the next config, so it matches the registers it stands beside
   a_refresh_cke: assert property (sdram_present(s_q.cfg) && s_q.ctrl[CTRL_SR_BIT] // RL9
                                   |-> !sdram_clk_enable)
      else $error("clock enable high during self-refresh");
   a_gp_cke: assert property (!sdram_present(s_q.cfg) // RL10
                              |-> sdram_clk_enable == s_q.ctrl[CTRL_GP_BIT])
      else $error("general output does not follow control bit");
   a_fifo_space3: assert property (!mem_pins.fifo_oe_n |-> !mem_pins.ce_n[3] && mem_pins.we_n) // RL11
      else $error("fifo output enable outside space 3 read");
   a_done_pulse: assert property (acc_done |=> !acc_done && !pending_access_flag_out)
      else $error("done longer than one cycle");
   a_div1_clk2: assert property (s_q.ctrl[1:0] == 2'h0 ##1 s_q.ctrl[1:0] == 2'h0 // RL3
                                 |-> divided_mem_clock_out == full_rate_mem_clock_out)
      else $error("undivided output clock 2 differs from clock 1");

   c_async_wait: cover property (s_q.st == ST_STROBE && s_q.mtype == EMI_MEM_ASYNC
                                 && !async_wait_ready_in ##1 acc_done);
   c_hold_cycle: cover property ($rose(hold_grant_out) ##[1:20] $fell(hold_grant_out));
   c_sync_fifo: cover property (!mem_pins.fifo_oe_n);
   c_sdram_wr: cover property (s_q.mtype == EMI_MEM_SDRAM && !mem_pins.we_n);

endmodule

// File: emi_mem_model.sv
// Memory-side partner: asynchronous memory that answers ready after a set wait
`timescale 1ns/1ps
module emi_mem_model
   import emi_pkg::*;
(
   input  wire logic       core_clk,
   input  emi_pins_t       pins,
   input  wire logic [7:0] wait_cyc,
   output logic            ready
);
   logic       sel;
   logic [7:0] cnt_q;

   // Selected while the controller drives a chip enable low
   assign sel = pins.drive && (pins.ce_n != 4'hf);

   // Cycles since select; saturates so long waits never wrap to ready
   always_ff @(posedge core_clk) begin
      if (!sel) cnt_q <= 8'h00;
      else if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
   end

   // Pull-up holds ready high when unselected; wait 0 answers promptly
   assign ready = !sel || (cnt_q >= wait_cyc);
endmodule

// File: emi_ctrl_bench.sv
// Self-checking bench for the memory interface control block
`timescale 1ns/1ps
module emi_ctrl_bench;
   import emi_pkg::*;
   logic        core_clk;
   logic        reset_n;
   logic [1:0]  straps;
   logic        ext_clk;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   emi_req_t    acc_req;
   logic        acc_done;
   logic        rdy;
   logic        claim;
   logic        grant;
   logic        pend;
   emi_pins_t   pins;
   logic        cke;
   logic        clk1;
   logic        clk2;
   logic [7:0]  wait_cyc;
   logic [7:0]  lfsr;
   logic [31:0] d;
   logic [3:0]  ce;
   logic [3:0]  lo;
   logic [1:0]  ty;
   int          fails, compares, k, s, w, t, p, dur, rdc, tce, d0;
   int          src_exp[4] = '{0, 1, 2, 0};
   int          per_exp[4] = '{10, 4, 6, 10};

   emi_ctrl emi_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
      .clock_source_straps(straps), .iface_clock_in(ext_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .acc_req(acc_req), .acc_done(acc_done), .async_wait_ready_in(rdy),
      .host_bus_claim_in(claim), .hold_grant_out(grant), .pending_access_flag_out(pend),
      .mem_pins(pins), .sdram_clk_enable(cke), .full_rate_mem_clock_out(clk1),
      .divided_mem_clock_out(clk2));

   emi_mem_model emi_mem_model_i (.core_clk(core_clk), .pins(pins),
      .wait_cyc(wait_cyc), .ready(rdy));

   // 125 MHz core clock; external clock of 10 core cycles, edges off the core edge
   always #4 core_clk = ~core_clk;
   always #40 ext_clk = ~ext_clk;

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // A wait that runs out ends the run at once
   task automatic tmo;
      fails++;
      $display("CHECK FAILED wait expected completion seen timeout");
      wrap_up();
   endtask

   // Straps are held through reset so the first edge after release sees them
   task automatic rst(input logic [1:0] sv);
      reset_n <= 1'b0;
      straps <= sv;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      v = reg_rdata;
   endtask

   // Core cycles between two rising edges of output clock 1 or 2
   task automatic per(input bit sel, output int pc);
      logic prv;
      logic cur;
      int   n;
      int   first;
      prv = 1'b1;
      first = -1;
      pc = 0;
      for (n = 0; n < 200; n++) begin
         @(posedge core_clk);
         cur = sel ? clk2 : clk1;
         if (cur === 1'b1 && prv === 1'b0) begin
            if (first >= 0) begin
               pc = n - first;
               return;
            end
            first = n;
         end
         prv = cur;
      end
      tmo();
   endtask

   // One access; records strobes seen low; host claim drops at cycle hold
   task automatic acc(input logic [3:0] ah, input logic wr, input int hold,
                      output int du, output int rc, output logic [3:0] cs,
                      output logic [3:0] seen, output int tc);
      int n;
      du = 0;
      rc = 0;
      cs = 4'h0;
      seen = 4'h0;
      tc = 0;
      @(posedge core_clk);
      acc_req <= '{1'b1, wr, ah};
      for (n = 1; n < 300; n++) begin
         @(posedge core_clk);
         if (n == hold) claim <= 1'b0;
         if (pins.ce_n !== 4'hf && tc == 0) tc = n;
         cs |= ~pins.ce_n;
         rc += (pins.rd_n === 1'b0);
         seen |= {pend, !pins.fifo_oe_n, !pins.we_n, !pins.oe_n};
         if (acc_done === 1'b1) begin
            acc_req.valid <= 1'b0;
            du = n;
            return;
         end
      end
      tmo();
   endtask

   initial begin
      core_clk = 1'b0;
      ext_clk = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      acc_req = '0;
      claim = 1'b0;
      wait_cyc = 8'h00;
      lfsr = 8'h19;
      fails = 0;
      compares = 0;
      d0 = 0;
      // Every strap code: source in status, output clock 1 at source rate
      for (k = 0; k < 4; k++) begin
         rst(k[1:0]);
         if (k == 0) begin
            chk("ce_n after reset", 32'hf, pins.ce_n);
            chk("drive after reset", 32'h1, pins.drive);
            chk("grant after reset", 32'h0, grant);
            chk("cke after reset", 32'h0, cke);
         end
         rreg(REG_STAT, d);
         chk("clock source", src_exp[k], d[1:0]);
         per(1'b0, p);
         chk("clk1 period", per_exp[k], p);
      end
      $display("test clock source done");
      rst(2'b01);
      for (k = 0; k < 3; k++) begin
         wreg(REG_CTRL, k);
         rreg(REG_CTRL, d);
         chk("ctrl readback", k, d);
         per(1'b1, p);
         per(1'b1, p);
         chk("clk2 period", 4 << k, p);
      end
      wreg(REG_STAT, 32'hffffffff);
      rreg(REG_STAT, d);
      chk("status read-only", 32'h1, d);
      rreg(8'h0c, d);
      chk("unmapped read", 32'h0, d);
      wreg(REG_CTRL, 32'h0);
      $display("test registers done");
      // Types async, sdram, sync role 0, sync role 1; every space, read and write
      for (t = 0; t < 4; t++) begin
         ty = (t < 2) ? t[1:0] : 2'h2;
         wreg(REG_CFG, {20'h0, (t == 3) ? 4'hf : 4'h0, {4{ty}}});
         for (s = 0; s < 4; s++) begin
            for (w = 0; w < 2; w++) begin
               acc(4'h8 + s[3:0], w[0], 0, dur, rdc, ce, lo, tce);
               chk("chip enable", 32'h1 << s, ce);
               chk("pending seen", 32'h1, lo[3]);
               chk("oe strobe", w == 0 || ty == 2'h1, lo[0]);
               chk("we strobe", w == 1, lo[1]);
               chk("fifo oe", w == 0 && ty == 2'h2 && s == 3, lo[2]);
               if (w == 0) chk("rd low count", (t == 0 || t == 3) ? 8 : 4, rdc);
               if (w == 1 && t == 0) chk("rd on async write", 0, rdc);
               if (t == 0 && w == 0 && s == 0) d0 = dur;
            end
         end
      end
      $display("test strobe roles done");
      wreg(REG_CFG, 32'h0);
      lfsr = lfsr_next(lfsr);
      wait_cyc <= 8'h14 + {4'h0, lfsr[3:0]};
      acc(4'h8, 1'b0, 0, dur, rdc, ce, lo, tce);
      chk("ready stretch", 1, dur > d0 && rdc >= int'(wait_cyc) - 4);
      wait_cyc <= 8'h00;
      acc(4'h2, 1'b0, 0, dur, rdc, ce, lo, tce);
      chk("unmapped ce", 0, ce);
      chk("unmapped time", 1, dur <= 6);
      wreg(REG_CFG, 32'h3);
      acc(4'h8, 1'b1, 0, dur, rdc, ce, lo, tce);
      chk("type none ce", 0, ce);
      wreg(REG_CFG, 32'h0);
      $display("test ready and decode done");
      @(posedge core_clk);
      claim <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("hold grant", 1, grant);
      chk("pins released", 0, pins.drive);
      acc(4'h8, 1'b0, 12, dur, rdc, ce, lo, tce);
      chk("no access in hold", 1, tce > 12);
      chk("pending in hold", 1, lo[3]);
      chk("grant dropped", 0, grant);
      $display("test hold done");
      wreg(REG_CTRL, 32'h8);
      repeat (3) @(posedge core_clk);
      chk("cke general out", 1, cke);
      wreg(REG_CFG, 32'h1);
      wreg(REG_CTRL, 32'h0);
      repeat (3) @(posedge core_clk);
      chk("cke sdram running", 1, cke);
      wreg(REG_CTRL, 32'h4);
      repeat (3) @(posedge core_clk);
      chk("cke self refresh", 0, cke);
      $display("test clock enable done");
      wrap_up();
   end
endmodule
